// File: pkg/bwf_pkg.sv
// Package for the write-forwarding block: register map, control
// field positions, state encodings, reset values and cycle counts.
// Assumes the Wishbone and PCI-facing logic run on one 100 MHz clock.
package bwf_pkg;
    // Register byte offsets
    localparam logic [3:0] BWF_OFF_CTRL = 4'h0;
    localparam logic [3:0] BWF_OFF_CADDR = 4'h4;
    localparam logic [3:0] BWF_OFF_CDATA = 4'h8;
    localparam logic [3:0] BWF_OFF_STAT = 4'hc;
    // Control field positions
    localparam int BWF_B_MWI = 0;
    localparam int BWF_B_FBB = 1;
    localparam int BWF_B_MWDISC = 2;
    localparam int BWF_B_PQTUNE = 3;
    localparam int BWF_B_RTYDIS = 4;
    localparam int BWF_B_MTOLONG = 5;
    localparam int BWF_B_MTODIS = 6;
    localparam int BWF_B_SERREN = 7;
    localparam int BWF_B_MAMODE = 8;
    localparam int BWF_B_CSRIO = 9;
    localparam int BWF_B_CLS = 10;
    localparam logic [15:0] BWF_CTRL_RST = 16'h0000;
    // Cache line sizes in dwords
    localparam logic [5:0] BWF_CLS_DEF = 6'h08;
    localparam logic [5:0] BWF_CLS_16 = 6'h10;
    localparam logic [5:0] BWF_CLS_32 = 6'h20;
    // PCI commands
    localparam logic [3:0] BWF_CMD_IOWR = 4'h3;
    localparam logic [3:0] BWF_CMD_MWI = 4'hf;
    localparam logic [3:0] BWF_CMD_CFGWR = 4'hb;
    // Retry limit in retries, master timeouts in PCI clocks
    localparam int BWF_RTY_MAX = 1 << 24;
    localparam int BWF_MTO_SHORT = 1 << 10;
    localparam int BWF_MTO_LONG = 1 << 15;
    // Target bus termination codes
    typedef enum logic [1:0] {BWF_T_TRDY, BWF_T_TABT, BWF_T_MABT, BWF_T_RETRY} bwf_term_t;
    typedef enum logic [2:0] {DQ_EMPTY, DQ_REQ, DQ_BUSY, DQ_DONE, DQ_DROP} bwf_dq_t;
endpackage : bwf_pkg

// File: hdl/bwf_core.sv
// Write-forwarding control for a two-bus bridge: posted-write tuning
// and the single-entry delayed write queue with a Wishbone slave.
// Assumes queue counts, boundaries and bus events come from same-clock
// logic; the PCI pin sequencers sit outside and follow these strobes.
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - MWI only when MWI enable set
// - Fast back-to-back needs prior grant and enable
// - Fast back-to-back only after write without STOP
// - Enter flow-through when target data starts early
// - Flow-through: end master when below line
// - Flow-through: disconnect initiator at aligned boundary
// - Flow-through same for write and MWI
// - Disconnect mode: disconnect at cache line boundary
// - Tune 0: retry below line, odd CLS-1
// - Tune 1: retry below half line
// - Full queue: retry, no data, target CLS
// - I/O and CSR-triggered writes go delayed
// - First attempt retried; queue if free, unique
// - Match ignores byte enables
// - CSR request built from register contents
// - Delayed write uses one 32-bit phase
// - Store termination type and parity error
// - Drop after retry limit unless disabled, SERR if enabled
// - Dropped write answered with target abort
// - Exact repeat gets stored answer, else retry
// - Map stored completion to initiator answer
// - Unclaimed completion dropped after master timeout
module bwf_core
    import bwf_pkg::*;
#(
    parameter int RTY_MAX = BWF_RTY_MAX,
    parameter int MTO_LONG = BWF_MTO_LONG
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Initiator bus attempt
    input wire logic in_req,
    input wire logic in_delayed,
    input wire logic [3:0] in_cmd,
    input wire logic [31:0] in_addr,
    input wire logic [31:0] in_data,
    input wire logic [3:0] in_be,
    input wire logic in_multi,
    input wire logic in_beat,
    input wire logic in_ended,
    input wire logic in_bound,
    input wire logic [6:0] pq_free,
    input wire logic [6:0] pq_level,
    input wire logic order_ok,
    // Initiator bus answer
    output logic tgt_accept,
    output logic tgt_retry,
    output logic tgt_trdy,
    output logic tgt_stop,
    output logic tgt_abort,
    // Target bus master side
    input wire logic gnt,
    input wire logic mst_active,
    input wire logic line_be_full,
    input wire logic pw_done,
    input wire logic pw_stopped,
    input wire logic tb_done,
    input wire logic [1:0] tb_term,
    input wire logic tb_perr,
    output logic flow,
    output logic mst_mwi,
    output logic mst_fbb,
    output logic mst_end,
    output logic dw_go,
    output logic [3:0] dw_cmd,
    output logic [31:0] dw_addr,
    output logic [31:0] dw_data,
    output logic [3:0] dw_be,
    output logic serr
);

    typedef struct packed {
        bwf_dq_t dq;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [31:0] data;
        logic [3:0] be;
        logic csr;
        logic [1:0] term;
        logic perr;
        logic [24:0] rty;
        logic [15:0] mto;
        logic [15:0] ctrl;
        logic [31:0] caddr;
        logic [31:0] rdat;
        logic ack;
        logic accept, retry, trdy, stop, abort;
        logic flow, mwi, fbb, mend, go, serr;
        logic gnt_d;
        logic clean;
    } bwf_st_t;

    bwf_st_t st_r, st_nxt;

    // Invalid sizes fall back to 8 dwords
    function automatic logic [5:0] bwf_cls(input logic [5:0] v);
        if (v == BWF_CLS_DEF || v == BWF_CLS_16 || v == BWF_CLS_32)
            return v;
        return BWF_CLS_DEF;
    endfunction : bwf_cls

    function automatic logic bwf_cls_ok(input logic [5:0] v);
        return v == BWF_CLS_DEF || v == BWF_CLS_16 || v == BWF_CLS_32;
    endfunction : bwf_cls_ok

    logic [5:0] cls;
    logic [6:0] need;
    logic line_end;
    logic match;
    logic exact;
    logic [15:0] mto_lim;

    always_comb
    begin
        cls = bwf_cls(st_r.ctrl[BWF_B_CLS +: 6]);
        if (st_r.ctrl[BWF_B_PQTUNE])
            need = {2'b00, cls[5:1]};
        else if (in_addr[2])
            need = {1'b0, cls} - 7'h01;
        else
            need = {1'b0, cls};
        line_end = (in_addr[7:2] & (cls - 6'h01)) == (cls - 6'h01);
        match = in_addr == st_r.addr && in_cmd == st_r.cmd;
        exact = match && in_data == st_r.data && in_be == st_r.be;
        mto_lim = st_r.ctrl[BWF_B_MTOLONG] ? 16'(MTO_LONG - 1) : 16'(BWF_MTO_SHORT - 1);
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
        st_nxt.accept = 1'b0;
        st_nxt.retry = 1'b0;
        st_nxt.trdy = 1'b0;
        st_nxt.stop = 1'b0;
        st_nxt.abort = 1'b0;
        st_nxt.mend = 1'b0;
        st_nxt.go = 1'b0;
        st_nxt.serr = 1'b0;
        st_nxt.gnt_d = gnt;

        // Wishbone access, one wait state
        if (wb_cyc_i && wb_stb_i && !st_r.ack)
        begin
            case (wb_adr_i)
                BWF_OFF_CTRL: st_nxt.rdat = {16'h0000, st_r.ctrl};
                BWF_OFF_CADDR: st_nxt.rdat = st_r.caddr;
                BWF_OFF_CDATA: st_nxt.rdat = st_r.data;
                BWF_OFF_STAT: st_nxt.rdat = {24'h000000, st_r.flow, st_r.perr,
                    st_r.term, st_r.csr, st_r.dq};
                default: st_nxt.rdat = 32'h00000000;
            endcase
            if (wb_we_i)
            begin
                case (wb_adr_i)
                    BWF_OFF_CTRL:
                    begin
                        if (wb_sel_i[0])
                            st_nxt.ctrl[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1])
                            st_nxt.ctrl[15:8] = wb_dat_i[15:8];
                    end
                    BWF_OFF_CADDR: st_nxt.caddr = wb_dat_i;
                    BWF_OFF_CDATA:
                    begin
                        // Data write triggers the remote cycle
                        if (st_r.dq == DQ_EMPTY)
                        begin
                            st_nxt.dq = DQ_REQ;
                            st_nxt.csr = 1'b1;
                            st_nxt.addr = st_r.caddr;
                            st_nxt.data = wb_dat_i;
                            st_nxt.be = wb_sel_i;
                            st_nxt.cmd = st_r.ctrl[BWF_B_CSRIO] ? BWF_CMD_IOWR : BWF_CMD_CFGWR;
                            st_nxt.rty = 25'h0000000;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Posted write admission and disconnect
        if (in_req && !in_delayed)
        begin
            if (pq_free < need)
                st_nxt.retry = 1'b1;
            else
                st_nxt.accept = 1'b1;
        end
        if (in_beat && !in_delayed)
        begin
            if (st_r.ctrl[BWF_B_MWDISC] && line_end)
                st_nxt.stop = 1'b1;
            if (in_cmd == BWF_CMD_MWI && line_end && pq_free < {1'b0, cls})
                st_nxt.stop = 1'b1;
            if (st_r.flow && in_bound)
                st_nxt.stop = 1'b1;
        end

        // Flow-through, same for write and MWI
        if (mst_active && !in_ended && !st_r.flow)
            st_nxt.flow = 1'b1;
        if (!mst_active)
            st_nxt.flow = 1'b0;
        if (st_r.flow && mst_active && pq_level < {1'b0, cls} && !st_r.mend)
            st_nxt.mend = 1'b1;

        st_nxt.mwi = st_r.ctrl[BWF_B_MWI] && bwf_cls_ok(st_r.ctrl[BWF_B_CLS +: 6])
            && line_be_full && pq_level >= {1'b0, cls};
        if (pw_done)
            st_nxt.clean = !pw_stopped;
        st_nxt.fbb = st_r.ctrl[BWF_B_FBB] && st_r.gnt_d && st_r.clean;

        // Delayed write queue
        case (st_r.dq)
            DQ_EMPTY:
            begin
                if (in_req && in_delayed)
                begin
                    st_nxt.retry = 1'b1;
                    st_nxt.dq = DQ_REQ;
                    st_nxt.csr = 1'b0;
                    st_nxt.addr = in_addr;
                    st_nxt.cmd = in_cmd;
                    st_nxt.data = in_data;
                    st_nxt.be = in_be;
                    st_nxt.rty = 25'h0000000;
                end
            end
            DQ_REQ:
            begin
                if (in_req && in_delayed)
                    st_nxt.retry = 1'b1;
                if (order_ok)
                begin
                    st_nxt.go = 1'b1;
                    st_nxt.dq = DQ_BUSY;
                end
            end
            DQ_BUSY:
            begin
                if (in_req && in_delayed)
                    st_nxt.retry = 1'b1;
                if (tb_done)
                begin
                    if (tb_term == BWF_T_RETRY)
                    begin
                        st_nxt.rty = st_r.rty + 25'h0000001;
                        st_nxt.dq = DQ_REQ;
                        if (!st_r.ctrl[BWF_B_RTYDIS] && st_r.rty == 25'(RTY_MAX - 1))
                        begin
                            st_nxt.dq = DQ_DROP;
                            st_nxt.serr = st_r.ctrl[BWF_B_SERREN];
                        end
                    end
                    else
                    begin
                        st_nxt.term = tb_term;
                        st_nxt.perr = tb_perr;
                        st_nxt.mto = 16'h0000;
                        st_nxt.dq = st_r.csr ? DQ_EMPTY : DQ_DONE;
                    end
                end
            end
            DQ_DONE:
            begin
                if (st_r.ctrl[BWF_B_MTODIS])
                    st_nxt.mto = st_r.mto + 16'h0001;
                if (in_req && in_delayed)
                begin
                    if (exact && order_ok)
                    begin
                        st_nxt.dq = DQ_EMPTY;
                        case (st_r.term)
                            BWF_T_TRDY:
                            begin
                                st_nxt.trdy = 1'b1;
                                st_nxt.stop = in_multi;
                            end
                            BWF_T_MABT:
                            begin
                                st_nxt.abort = st_r.ctrl[BWF_B_MAMODE];
                                st_nxt.trdy = !st_r.ctrl[BWF_B_MAMODE];
                                st_nxt.stop = in_multi && !st_r.ctrl[BWF_B_MAMODE];
                            end
                            default: st_nxt.abort = 1'b1;
                        endcase
                    end
                    else
                        st_nxt.retry = 1'b1;
                end
                else if (st_r.ctrl[BWF_B_MTODIS] && st_r.mto == mto_lim)
                begin
                    st_nxt.dq = DQ_EMPTY;
                    st_nxt.serr = st_r.ctrl[BWF_B_SERREN];
                end
            end
            DQ_DROP:
            begin
                if (in_req && in_delayed)
                begin
                    if (match)
                    begin
                        st_nxt.abort = 1'b1;
                        st_nxt.dq = DQ_EMPTY;
                    end
                    else
                        st_nxt.retry = 1'b1;
                end
                else if (st_r.csr)
                    st_nxt.dq = DQ_EMPTY;
            end
            default: st_nxt.dq = DQ_EMPTY;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.dq <= DQ_EMPTY;
            st_r.ctrl <= BWF_CTRL_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign wb_dat_o = st_r.rdat;
    assign wb_ack_o = st_r.ack;
    assign tgt_accept = st_r.accept;
    assign tgt_retry = st_r.retry;
    assign tgt_trdy = st_r.trdy;
    assign tgt_stop = st_r.stop;
    assign tgt_abort = st_r.abort;
    assign flow = st_r.flow;
    assign mst_mwi = st_r.mwi;
    assign mst_fbb = st_r.fbb;
    assign mst_end = st_r.mend;
    assign dw_go = st_r.go;
    assign dw_cmd = st_r.cmd;
    assign dw_addr = st_r.addr;
    assign dw_data = st_r.data;
    assign dw_be = st_r.be;
    assign serr = st_r.serr;

    // Checks
    sequence s_dq_attempt;
        in_req && in_delayed && st_r.dq == DQ_EMPTY;
    endsequence
    sequence s_bus_retry;
        st_r.dq == DQ_BUSY && tb_done && tb_term == BWF_T_RETRY;
    endsequence

    a_mwi_gate: assert property (@(posedge clk) disable iff (!rst_n)
        mst_mwi |-> $past(st_r.ctrl[BWF_B_MWI])) else $error("MWI without enable");
    a_fbb_gate: assert property (@(posedge clk) disable iff (!rst_n)
        mst_fbb |-> $past(gnt, 2) && $past(st_r.ctrl[BWF_B_FBB])) else $error("FBB without grant");
    a_flow_enter: assert property (@(posedge clk) disable iff (!rst_n)
        mst_active && !in_ended && !flow |=> flow) else $error("Flow-through not entered");
    a_pq_full: assert property (@(posedge clk) disable iff (!rst_n)
        in_req && !in_delayed && pq_free < need |=> tgt_retry && !tgt_accept)
        else $error("Full queue accepted data");
    a_first_retry: assert property (@(posedge clk) disable iff (!rst_n)
        s_dq_attempt |=> tgt_retry ##0 st_r.dq == DQ_REQ) else $error("First attempt not retried");
    a_single_go: assert property (@(posedge clk) disable iff (!rst_n)
        dw_go |=> !dw_go) else $error("Delayed write issued twice");
    a_retry_drop: assert property (@(posedge clk) disable iff (!rst_n)
        s_bus_retry ##0 (st_r.rty == 25'(RTY_MAX - 1) && !st_r.ctrl[BWF_B_RTYDIS])
        |=> st_r.dq == DQ_DROP && serr == $past(st_r.ctrl[BWF_B_SERREN]))
        else $error("Retry limit not honoured");
    a_drop_abort: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.dq == DQ_DROP && in_req && in_delayed && match |=> tgt_abort && !tgt_trdy)
        else $error("Dropped write not aborted");
    a_ma_mode: assert property (@(posedge clk) disable iff (!rst_n)
        tgt_trdy |-> !tgt_abort) else $error("TRDY with abort");
endmodule : bwf_core
`default_nettype wire

// File: testbench/bwf_tgt_model.sv
// Target bus model: answers each single-phase delayed write.
// Assumes dw_go is a one-cycle pulse on clk; the bench picks the code.
`timescale 1ns/1ps
`default_nettype none
module bwf_tgt_model (
    // Clock
    input wire logic clk,
    // Bridge side
    input wire logic dw_go,
    // Scenario control
    input wire logic [1:0] term_sel,
    input wire logic perr_sel,
    input wire logic [3:0] dly,
    // Answer
    output logic tb_done,
    output logic [1:0] tb_term,
    output logic tb_perr
);
    logic busy_r;
    logic [3:0] cnt_r;
    initial
    begin
        busy_r = 1'b0;
        cnt_r = 4'h0;
        tb_done = 1'b0;
        tb_term = 2'h0;
        tb_perr = 1'b0;
    end
    // Idle code lines toggle so a stale code is never mistaken for news
    always @(posedge clk)
    begin
        tb_done <= 1'b0;
        tb_term <= ~tb_term;
        tb_perr <= ~tb_perr;
        if (dw_go === 1'b1)
        begin
            busy_r <= 1'b1;
            cnt_r <= dly;
        end
        else if (busy_r && cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
        else if (busy_r)
        begin
            busy_r <= 1'b0;
            tb_done <= 1'b1;
            tb_term <= term_sel;
            tb_perr <= perr_sel;
        end
    end
endmodule : bwf_tgt_model
`default_nettype wire

// File: testbench/tb_bwf_core.sv
// Bench for the write-forwarding core: Wishbone tasks and initiator
// attempts against a target bus model. Assumes one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_bwf_core;
    import bwf_pkg::*;
    localparam int MTO = 64;
    logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0] wb_adr_i, wb_sel_i, in_cmd, in_be, dw_cmd, dw_be, dly;
    logic [31:0] wb_dat_i, wb_dat_o, in_addr, in_data, dw_addr, dw_data, rd;
    logic in_req, in_delayed, in_multi, order_ok, gnt, mst_active, line_be_full;
    logic in_ended, pw_done, pw_stopped;
    logic tgt_accept, tgt_retry, tgt_trdy, tgt_stop, tgt_abort, tb_done, tb_perr;
    logic flow, mst_mwi, mst_fbb, mst_end, dw_go, serr, perr_sel;
    logic [6:0] pq_free, pq_level;
    logic [1:0] tb_term, term_sel;
    logic [4:0] ans;
    int errors = 0;
    int check_count = 0;
    int n;
    bwf_core #(.RTY_MAX(8), .MTO_LONG(MTO)) dut_u (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .in_req(in_req), .in_delayed(in_delayed), .in_cmd(in_cmd), .in_addr(in_addr),
        .in_data(in_data), .in_be(in_be), .in_multi(in_multi), .in_beat(1'b0),
        .in_ended(in_ended), .in_bound(1'b0), .pq_free(pq_free), .pq_level(pq_level),
        .order_ok(order_ok), .tgt_accept(tgt_accept), .tgt_retry(tgt_retry),
        .tgt_trdy(tgt_trdy), .tgt_stop(tgt_stop), .tgt_abort(tgt_abort), .gnt(gnt),
        .mst_active(mst_active), .line_be_full(line_be_full), .pw_done(pw_done),
        .pw_stopped(pw_stopped), .tb_done(tb_done), .tb_term(tb_term), .tb_perr(tb_perr),
        .flow(flow), .mst_mwi(mst_mwi), .mst_fbb(mst_fbb), .mst_end(mst_end),
        .dw_go(dw_go), .dw_cmd(dw_cmd), .dw_addr(dw_addr), .dw_data(dw_data),
        .dw_be(dw_be), .serr(serr));
    bwf_tgt_model tgt_u (.clk(clk), .dw_go(dw_go), .term_sel(term_sel),
        .perr_sel(perr_sel), .dly(dly), .tb_done(tb_done), .tb_term(tb_term),
        .tb_perr(tb_perr));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("Counts: %0d checks, %0d errors", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic hang(input string what);
        errors++;
        $display("ERROR %s expected event seen none", what);
        wrap_up();
    endtask : hang
    // Classic cycle; release only after ack was sampled high
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] sel);
        int i;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        i = 0;
        // Ack and data are sampled at the edge; release on that same edge
        do
        begin
            @(posedge clk);
            i++;
            if (i > 8)
                hang("wishbone ack");
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic poll_stat(input logic [2:0] exp);
        int i;
        for (i = 0; i < 20; i++)
        begin
            wb(1'b0, BWF_OFF_STAT, 32'h0, 4'hf);
            if (rd[2:0] === exp)
                break;
        end
        chk("queue state", {29'h0, exp}, {29'h0, rd[2:0]});
    endtask : poll_stat
    task automatic wait_sig(input int which, input int lim, output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk);
            cyc++;
            if (cyc > lim)
                hang(which == 0 ? "write phase" : "system error");
        end
        while (!((which == 0) ? (dw_go === 1'b1) : (serr === 1'b1)));
    endtask : wait_sig
    task automatic att(input logic dl, input logic [3:0] cmd, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] be, input logic mu, input logic [6:0] fr);
        int i;
        @(posedge clk);
        in_req <= 1'b1;
        in_delayed <= dl;
        in_cmd <= cmd;
        in_addr <= a;
        in_data <= d;
        in_be <= be;
        in_multi <= mu;
        pq_free <= fr;
        @(posedge clk);
        in_req <= 1'b0;
        ans = 5'h00;
        for (i = 0; i < 6; i++)
        begin
            // Answer stands one cycle; sampled at the edge that ends it
            @(posedge clk);
            ans = {tgt_accept, tgt_retry, tgt_trdy, tgt_stop, tgt_abort};
            if (ans != 5'h00)
                break;
        end
    endtask : att
    logic [1:0] tm [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic [0:3] mam = 4'b0001;
    logic [0:3] mul = 4'b1000;
    logic [4:0] ex [4] = '{5'h06, 5'h01, 5'h04, 5'h01};
    logic [0:5] ptu = 6'b000011;
    logic [0:5] pod = 6'b001100;
    logic [0:5] prt = 6'b010101;
    int pfr [6] = '{8, 7, 7, 6, 4, 3};
    initial
    begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, in_req, in_delayed, in_multi} = 6'h00;
        {wb_adr_i, wb_sel_i, in_cmd, in_be, dly, term_sel, perr_sel} = 23'h0;
        {wb_dat_i, in_addr, in_data, pq_free, pq_level} = 110'h0;
        {order_ok, gnt, mst_active, line_be_full} = 4'h9;
        {in_ended, pw_done, pw_stopped} = 3'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, BWF_OFF_CTRL, 32'h0, 4'hf);
        chk("ctrl reset", {16'h0, BWF_CTRL_RST}, rd);
        wb(1'b1, BWF_OFF_CTRL, 32'h41ff, 4'h3);
        wb(1'b1, BWF_OFF_CTRL, 32'h0, 4'h2);
        wb(1'b0, BWF_OFF_CTRL, 32'h0, 4'hf);
        chk("ctrl bytes", 32'h00ff, rd);
        wb(1'b0, 4'h2, 32'h0, 4'hf);
        chk("unmapped read", 32'h0, rd);
        $display("test registers done");
        pq_level <= 7'h08;
        // MWI also needs a valid line size: 8 dwords in the size field
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, BWF_OFF_CTRL, 32'h2000 | 32'(k), 4'h3);
            repeat (3) @(posedge clk);
            chk("mwi select", 32'(k), {31'h0, mst_mwi});
        end
        for (int k = 0; k < 6; k++)
        begin
            wb(1'b1, BWF_OFF_CTRL, {28'h0, ptu[k], 3'h0}, 4'h3);
            att(1'b0, 4'h7, {29'h20, pod[k], 2'h0}, 32'h0, 4'hf, 1'b0, 7'(pfr[k]));
            chk("posted answer", prt[k] ? 32'h08 : 32'h10, {27'h0, ans});
        end
        $display("test posted done");
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, BWF_OFF_CTRL, {23'h0, mam[k], 8'h00}, 4'h3);
            term_sel <= tm[k];
            perr_sel <= k[0];
            dly <= 4'(k);
            att(1'b1, BWF_CMD_IOWR, 32'h1000, 32'(32'h5a00 + k), 4'(1 << k), mul[k], 7'h40);
            chk("first answer", 32'h08, {27'h0, ans});
            wait_sig(0, 20, n);
            chk("phase data", 32'(32'h5a00 + k), dw_data);
            chk("phase be", 32'(1 << k), {28'h0, dw_be});
            att(1'b1, BWF_CMD_IOWR, 32'h1400, 32'h0, 4'hf, 1'b0, 7'h40);
            chk("other attempt", 32'h08, {27'h0, ans});
            poll_stat(3'h3);
            chk("status", {tm[k], 1'(k), 4'h0}, {rd[5:4], rd[6], 4'h0});
            order_ok <= 1'b0;
            att(1'b1, BWF_CMD_IOWR, 32'h1000, 32'(32'h5a00 + k), 4'(1 << k), mul[k], 7'h40);
            chk("held answer", 32'h08, {27'h0, ans});
            order_ok <= 1'b1;
            att(1'b1, BWF_CMD_IOWR, 32'h1000, 32'(32'h5a00 + k), 4'(1 << k), mul[k], 7'h40);
            chk("repeat answer", 32'(ex[k]), {27'h0, ans});
        end
        $display("test delayed done");
        wb(1'b1, BWF_OFF_CTRL, 32'h0080, 4'h3);
        term_sel <= BWF_T_RETRY;
        dly <= 4'h0;
        att(1'b1, BWF_CMD_IOWR, 32'h2000, 32'h0, 4'hf, 1'b0, 7'h40);
        wait_sig(1, 400, n);
        poll_stat(3'h4);
        att(1'b1, BWF_CMD_IOWR, 32'h2000, 32'h0, 4'hf, 1'b0, 7'h40);
        chk("dropped answer", 32'h01, {27'h0, ans});
        $display("test retry limit done");
        wb(1'b1, BWF_OFF_CTRL, 32'h00e0, 4'h3);
        term_sel <= BWF_T_TRDY;
        att(1'b1, BWF_CMD_IOWR, 32'h3000, 32'h0, 4'hf, 1'b0, 7'h40);
        poll_stat(3'h3);
        wait_sig(1, 2 * MTO, n);
        chk("timeout span", 32'h1, {31'h0, n >= MTO - 14 && n <= MTO + 1});
        poll_stat(3'h0);
        $display("test timeout done");
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, BWF_OFF_CTRL, {22'h0, k[0], 9'h0}, 4'h3);
            order_ok <= 1'b0;
            wb(1'b1, BWF_OFF_CADDR, 32'h0a10, 4'hf);
            wb(1'b1, BWF_OFF_CDATA, 32'h12345678, 4'h6);
            order_ok <= 1'b1;
            wait_sig(0, 20, n);
            chk("csr cmd", {28'h0, k ? BWF_CMD_IOWR : BWF_CMD_CFGWR}, {28'h0, dw_cmd});
            chk("csr addr", 32'h0a10, dw_addr);
            chk("csr data", 32'h12345678, dw_data);
            chk("csr be", 32'h6, {28'h0, dw_be});
            poll_stat(3'h0);
        end
        $display("test csr done");
        // Fast back-to-back: first after a stopped write, then after a clean one
        wb(1'b1, BWF_OFF_CTRL, 32'h0002, 4'h3);
        gnt <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            pw_done <= 1'b1;
            pw_stopped <= (k == 0);
            @(posedge clk);
            pw_done <= 1'b0;
            repeat (2) @(posedge clk);
            chk("fbb after write", 32'(k), {31'h0, mst_fbb});
        end
        gnt <= 1'b0;
        repeat (3) @(posedge clk);
        chk("fbb without grant", 32'h0, {31'h0, mst_fbb});
        pq_level <= 7'h04;
        mst_active <= 1'b1;
        repeat (2) @(posedge clk);
        chk("flow entry", 32'h1, {31'h0, flow});
        @(posedge clk);
        chk("flow end", 32'h1, {31'h0, mst_end});
        mst_active <= 1'b0;
        in_ended <= 1'b1;
        @(posedge clk);
        mst_active <= 1'b1;
        repeat (2) @(posedge clk);
        chk("flow after end", 32'h0, {31'h0, flow});
        mst_active <= 1'b0;
        in_ended <= 1'b0;
        $display("test master side done");
        wrap_up();
    end
endmodule : tb_bwf_core
`default_nettype wire
